/* ioc_map.vh */
// register offsets, field positions and timing counts for the i/o channel control block
`ifndef IOC_MAP_VH
`define IOC_MAP_VH
`define IOC_CLK_MHZ 200
`define IOC_TMO_US 100
`define IOC_TMO_CYC (`IOC_TMO_US * `IOC_CLK_MHZ)
`define IOC_CLR_NS 5500
`define IOC_CLR_CYC ((`IOC_CLR_NS * `IOC_CLK_MHZ + 999) / 1000)
`define IOC_A_CMD 8'h00
`define IOC_A_LOCK 8'h04
`define IOC_A_STAT 8'h08
`define IOC_A_CODE 8'h0c
`define IOC_A_RFADR 8'h10
`define IOC_A_RFDAT 8'h14
`define IOC_A_BUSY 8'h18
`define IOC_A_ADDR 8'h1c
`define IOC_A_LAST 8'h20
`define IOC_OP_LOCKOUT 4'h1
`define IOC_OP_SET_FLOAT_FAULT_OP 4'h2
`define IOC_OP_SET_DECIMAL_FAULT_OP 4'h3
`define IOC_OP_CLEAR_CHANNELS_OP 4'h4
`define IOC_OP_BCCLR 4'h5
`define IOC_OP_CONN 4'h6
`define IOC_OP_FSEL 4'h7
`define IOC_OP_STIO 4'h8
`define IOC_OP_CLRFLT 4'h9
`define IOC_BIT_TYPE 8
`define IOC_BIT_N09 9
`define IOC_BIT_N10 10
`define IOC_BIT_SM 11
`define IOC_CODE_WIN 3'h0
`define IOC_CODE_COUT 3'h1
`define IOC_CODE_WOUT 3'h2
`define IOC_CODE_CIN 3'h3
`define IOC_CODE_WINA 3'h4
`define IOC_CODE_COUTA 3'h5
`define IOC_CODE_WOUTA 3'h6
`define IOC_CODE_CINA 3'h7
`endif

/* ioc_top.v */
// i/o channel control: lockout, faults, clears, connect/select, storage i/o words
// Functional notes
// [R1] lockout mask bit n locks out channel n; several may be set
// [R2] lockout bit clears on termination, channel clear, or negate-lockout input
// [R3] set-float-fault command sets float fault flag like a real fault
// [R4] set-decimal-fault command sets bcd fault flag like a real fault
// [R5] storage i/o handed to channel once read/write asserted; main resumes
// [R6] file words 00-07 per channel hold current address word
// [R7] file words 10-17 per channel hold last address word, adjusted
// [R8] word-addressed storage i/o shifts addresses left two, then character addresses
// [R9] executive mode copies state number from accumulator low bits to upper digit
// [R10] op code written into upper digit of current-address word
// [R11] clear-channels clears masked channels only, equipment untouched
// [R12] block clear mask: bits 0-7 channels, 8 typewriter, 11 search/move
// [R13] bits 9,10 equal: clear channel state and send 5.5 us clear pulse
// [R14] bit 9 clear, bit 10 set: clear channels, no clear pulse
// [R15] bit 8 clears typewriter plus type load/dump logic
// [R16] connect sends 12-bit code with connect enable on chosen channel
// [R17] connect reply in 100 us gives p+2; reject/timeout/busy gives p+1
// [R18] function select sends code with function enable; branches like connect
// [R19] no answer in 100 us makes the channel generate reject itself
// [R20] channel busy while read/write active or earlier reply/reject present
// [R21] controller answers reply or reject within 100 us
// [R22] peripheral rejects codes it cannot safely carry out
// [R23] lockout suppresses channel external interrupts only while channel busy; code masks only while chan_rw_active is set, not on reply/reject
// [R24] timeout counted in clock cycles from enable assertion
`timescale 1ns/1ps
`include "ioc_map.vh"
module ioc_top (
    input wire mclk,
    input wire rst_n,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire [7:0] chan_rw_active,
    input wire [7:0] chan_terminate,
    input wire [7:0] negate_lockout,
    input wire [7:0] ext_irq_in,
    input wire [7:0] reply_in,
    input wire [7:0] reject_in,
    output reg [7:0] ext_irq_out,
    output reg [11:0] chan_code_q,
    output reg [7:0] connect_en_q,
    output reg [7:0] func_en_q,
    output reg [7:0] chan_clear_q,
    output reg [7:0] equip_clear_q,
    output reg [7:0] start_io_q,
    output reg type_clear_q,
    output reg search_move_clear_q
);
    reg rst_s1_q;
    reg rst_s2_q;
    wire rst_in_n = rst_s2_q;
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end

    localparam integer TMO_INT = `IOC_TMO_CYC;
    localparam integer CLR_INT = `IOC_CLR_CYC;
    localparam [14:0] TMO_CYC = TMO_INT[14:0];
    localparam [10:0] CLR_CYC = CLR_INT[10:0];
    localparam [1:0] HS_IDLE = 2'd0;
    localparam [1:0] HS_WAIT = 2'd1;
    localparam [1:0] HS_DONE = 2'd2;

    reg [7:0] lockout_q;
    reg float_fault_q;
    reg bcd_fault_q;
    reg [1:0] hs_state_q;
    reg [14:0] tmo_cnt_q;
    reg [2:0] hs_chan_q;
    reg hs_result_q;
    reg hs_timeout_q;
    reg hs_busy_rej_q;
    reg [10:0] clr_cnt_q;
    reg [31:0] cmd_q;
    reg [31:0] code_q;
    reg [31:0] addr_q;
    reg [31:0] last_q;
    reg [3:0] rf_adr_q;
    reg [23:0] rfile [0:15];
    reg aw_hold_q;
    reg w_hold_q;
    reg [7:0] aw_adr_q;
    reg [31:0] w_dat_q;
    integer i;

    // write channel capture in either order
    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    wire wr_go = aw_hold_q && w_hold_q && !s_axi_bvalid;
    wire [7:0] busy = chan_rw_active | reply_in | reject_in; // R20

    // command decode from write of cmd register
    wire cmd_go = wr_go && (aw_adr_q == `IOC_A_CMD);
    wire [3:0] op = w_dat_q[27:24];
    wire [11:0] mask = w_dat_q[11:0];
    wire [2:0] chn = w_dat_q[14:12];
    wire [2:0] ocode = w_dat_q[18:16];
    wire exec_mode = w_dat_q[19];
    wire word_addr = (ocode == `IOC_CODE_WIN) || (ocode == `IOC_CODE_WOUT);

    wire clr_pulse_ok = (mask[`IOC_BIT_N09] == mask[`IOC_BIT_N10]); // R13 R14
    wire clear_channels_op_go = cmd_go && (op == `IOC_OP_CLEAR_CHANNELS_OP);
    wire bcc_go = cmd_go && (op == `IOC_OP_BCCLR);
    wire [7:0] clr_sel = (clear_channels_op_go || bcc_go) ? mask[7:0] : 8'h00; // R11 R12

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            aw_adr_q <= 8'h00;
            w_dat_q <= 32'h0;
        end else if (!rst_in_n) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
        end else begin
            s_axi_awready <= !aw_hold_q && !aw_take;
            s_axi_wready <= !w_hold_q && !w_take;
            if (aw_take) begin
                aw_hold_q <= 1'b1;
                aw_adr_q <= s_axi_awaddr;
            end
            if (w_take) begin
                w_hold_q <= 1'b1;
                w_dat_q <= s_axi_wdata;
            end
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (aw_adr_q <= `IOC_A_LAST && aw_adr_q[1:0] == 2'b00)
                    ? 2'b00 : 2'b10;
                aw_hold_q <= 1'b0;
                w_hold_q <= 1'b0;
                s_axi_awready <= 1'b0;
                s_axi_wready <= 1'b0;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // software writable data registers
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            code_q <= 32'h0;
            addr_q <= 32'h0;
            last_q <= 32'h0;
            rf_adr_q <= 4'h0;
            cmd_q <= 32'h0;
        end else if (wr_go) begin
            case (aw_adr_q)
                `IOC_A_CMD: cmd_q <= w_dat_q;
                `IOC_A_CODE: code_q <= w_dat_q;
                `IOC_A_ADDR: addr_q <= w_dat_q;
                `IOC_A_LAST: last_q <= w_dat_q;
                `IOC_A_RFADR: rf_adr_q <= w_dat_q[3:0];
                default: cmd_q <= cmd_q;
            endcase
        end
    end

    // lockout mask and fault flags
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            lockout_q <= 8'h00;
            float_fault_q <= 1'b0;
            bcd_fault_q <= 1'b0;
            ext_irq_out <= 8'h00;
        end else begin
            for (i = 0; i < 8; i = i + 1) begin
                if (chan_terminate[i] || clr_sel[i] || negate_lockout[i])
                    lockout_q[i] <= 1'b0; // R2
                else if (cmd_go && op == `IOC_OP_LOCKOUT && mask[i])
                    lockout_q[i] <= 1'b1; // R1
            end
            // R23
            ext_irq_out <= ext_irq_in & ~(lockout_q & chan_rw_active);
            if (cmd_go && op == `IOC_OP_SET_FLOAT_FAULT_OP)
                float_fault_q <= 1'b1; // R3
            else if (cmd_go && op == `IOC_OP_CLRFLT && mask[0])
                float_fault_q <= 1'b0;
            if (cmd_go && op == `IOC_OP_SET_DECIMAL_FAULT_OP)
                bcd_fault_q <= 1'b1; // R4
            else if (cmd_go && op == `IOC_OP_CLRFLT && mask[1])
                bcd_fault_q <= 1'b0;
        end
    end

    // clears, clear pulse timer
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            chan_clear_q <= 8'h00;
            equip_clear_q <= 8'h00;
            clr_cnt_q <= 11'd0;
            type_clear_q <= 1'b0;
            search_move_clear_q <= 1'b0;
        end else begin
            chan_clear_q <= clr_sel; // R11 R12
            type_clear_q <= bcc_go && mask[`IOC_BIT_TYPE]; // R15
            search_move_clear_q <= bcc_go && mask[`IOC_BIT_SM]; // R12
            if (bcc_go && clr_pulse_ok && mask[7:0] != 8'h00) begin
                equip_clear_q <= mask[7:0]; // R13
                clr_cnt_q <= CLR_CYC;
            end else if (clr_cnt_q > 11'd1) begin
                clr_cnt_q <= clr_cnt_q - 11'd1;
            end else begin
                clr_cnt_q <= 11'd0;
                equip_clear_q <= 8'h00;
            end
        end
    end

    // connect / function select handshake
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            hs_state_q <= HS_IDLE;
            tmo_cnt_q <= 15'd0;
            hs_chan_q <= 3'd0;
            hs_result_q <= 1'b0;
            hs_timeout_q <= 1'b0;
            hs_busy_rej_q <= 1'b0;
            connect_en_q <= 8'h00;
            func_en_q <= 8'h00;
            chan_code_q <= 12'h000;
        end else begin
            case (hs_state_q)
                HS_IDLE, HS_DONE: begin
                    if (cmd_go && (op == `IOC_OP_CONN || op == `IOC_OP_FSEL)) begin
                        hs_chan_q <= chn;
                        hs_timeout_q <= 1'b0;
                        hs_result_q <= 1'b0;
                        if (busy[chn] || clr_cnt_q != 11'd0) begin
                            hs_busy_rej_q <= 1'b1; // R17 R20
                            hs_state_q <= HS_DONE;
                        end else begin
                            hs_busy_rej_q <= 1'b0;
                            chan_code_q <= mask; // R16 R18
                            if (op == `IOC_OP_CONN)
                                connect_en_q[chn] <= 1'b1; // R16
                            else
                                func_en_q[chn] <= 1'b1; // R18
                            tmo_cnt_q <= TMO_CYC; // R24
                            hs_state_q <= HS_WAIT;
                        end
                    end
                end
                HS_WAIT: begin
                    if (reply_in[hs_chan_q] || reject_in[hs_chan_q] || tmo_cnt_q == 15'd1) begin
                        hs_result_q <= reply_in[hs_chan_q] && !reject_in[hs_chan_q]; // R17
                        hs_timeout_q <= !reply_in[hs_chan_q] && !reject_in[hs_chan_q]; // R19
                        connect_en_q <= 8'h00;
                        func_en_q <= 8'h00;
                        tmo_cnt_q <= 15'd0;
                        hs_state_q <= HS_DONE;
                    end else begin
                        tmo_cnt_q <= tmo_cnt_q - 15'd1; // R24
                    end
                end
                default: hs_state_q <= HS_IDLE;
            endcase
        end
    end

    // storage i/o start and file words
    wire stio_go = cmd_go && (op == `IOC_OP_STIO);
    wire [17:0] first_ca = word_addr ? {addr_q[15:0], 2'b00} : addr_q[17:0]; // R8
    wire [17:0] last_ca = word_addr ? {last_q[15:0], 2'b00} : last_q[17:0]; // R8
    wire [2:0] digit = exec_mode ? w_dat_q[22:20] : ocode; // R9 R10
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            start_io_q <= 8'h00;
            for (i = 0; i < 16; i = i + 1)
                rfile[i] <= 24'h0;
        end else begin
            start_io_q <= 8'h00;
            if (stio_go && !busy[chn]) begin
                start_io_q[chn] <= 1'b1; // R5
                rfile[{1'b0, chn}] <= {digit, 3'b000, first_ca}; // R6 R9 R10
                rfile[{1'b1, chn}] <= {6'h00, last_ca}; // R7
            end
        end
    end

    // read channel
    wire [23:0] rf_word = rfile[rf_adr_q];
    reg [31:0] rd_mux;
    always @* begin
        case (s_axi_araddr)
            `IOC_A_CMD: rd_mux = cmd_q;
            `IOC_A_LOCK: rd_mux = {24'h0, lockout_q};
            `IOC_A_STAT: rd_mux = {24'h0, hs_state_q, hs_busy_rej_q, hs_timeout_q,
                hs_result_q, (hs_state_q == HS_WAIT), bcd_fault_q, float_fault_q};
            `IOC_A_CODE: rd_mux = code_q;
            `IOC_A_RFADR: rd_mux = {28'h0, rf_adr_q};
            `IOC_A_RFDAT: rd_mux = {8'h00, rf_word};
            `IOC_A_BUSY: rd_mux = {24'h0, busy};
            `IOC_A_ADDR: rd_mux = addr_q;
            `IOC_A_LAST: rd_mux = last_q;
            default: rd_mux = 32'h0;
        endcase
    end
    wire rd_ok = (s_axi_araddr <= `IOC_A_LAST) && (s_axi_araddr[1:0] == 2'b00);
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= 2'b00;
        end else if (!rst_in_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_ok ? rd_mux : 32'h0;
                s_axi_rresp <= rd_ok ? 2'b00 : 2'b10;
            end else if (s_axi_rvalid) begin
                if (s_axi_rready)
                    s_axi_rvalid <= 1'b0;
            end else begin
                s_axi_arready <= 1'b1;
            end
        end
    end
endmodule // ioc_top

/* ioc_chk.sv */
// concurrent checks on the i/o channel control ports
`timescale 1ns/1ps
module ioc_chk (
    input wire mclk,
    input wire rst_n,
    input wire [7:0] chan_rw_active,
    input wire [7:0] ext_irq_in,
    input wire [7:0] reply_in,
    input wire [7:0] reject_in,
    input wire [7:0] ext_irq_out,
    input wire [11:0] chan_code_q,
    input wire [7:0] connect_en_q,
    input wire [7:0] func_en_q,
    input wire [7:0] chan_clear_q,
    input wire [7:0] equip_clear_q,
    input wire [7:0] start_io_q
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    wire [7:0] en = connect_en_q | func_en_q;
    wire [7:0] ans = reply_in | reject_in;
    wire [7:0] bsy = chan_rw_active | ans | en | equip_clear_q;
    a_clr_pulse: assert property (|chan_clear_q |=> chan_clear_q == 8'h00)
        else $error("channel clear longer than one cycle");
    a_start_pulse: assert property (|start_io_q |=> start_io_q == 8'h00)
        else $error("start pulse longer than one cycle");
    a_irq_free: assert property ($past(bsy) == 8'h00 |-> ext_irq_out == $past(ext_irq_in))
        else $error("interrupt held back on an idle channel");
    a_irq_subset: assert property ((ext_irq_out & ~$past(ext_irq_in)) == 8'h00)
        else $error("interrupt out without interrupt in");
    a_code_hold: assert property (|(en & $past(en)) |-> $stable(chan_code_q))
        else $error("code changed while enable high");
    genvar i;
    for (i = 0; i < 8; i = i + 1) begin : g_ch
        reg [14:0] cnt_q;
        reg [10:0] ecnt_q;
        reg got_q;
        always @(posedge mclk or negedge rst_n) begin
            if (!rst_n) begin
                cnt_q <= 15'h0000;
                ecnt_q <= 11'h000;
                got_q <= 1'b0;
            end else begin
                cnt_q <= en[i] ? cnt_q + 15'h0001 : 15'h0000;
                ecnt_q <= equip_clear_q[i] ? ecnt_q + 11'h001 : 11'h000;
                got_q <= en[i] & (got_q | ans[i] | chan_clear_q[i]);
            end
        end
        a_tmo_cap: assert property (cnt_q <= 15'd20002)
            else $error("enable outlived the timeout");
        a_no_early: assert property ($fell(en[i]) |-> got_q || cnt_q >= 15'd19998)
            else $error("enable dropped early without an answer");
        a_en_drop: assert property (en[i] && ans[i] |-> ##[1:3] !en[i])
            else $error("enable kept after an answer");
        a_equip_len: assert property ($fell(equip_clear_q[i]) |-> ecnt_q == 11'd1100)
            else $error("equipment clear length wrong");
        a_busy_no_en: assert property ($rose(en[i]) |-> !$past(chan_rw_active[i]))
            else $error("enable raised on a busy channel");
    end
endmodule // ioc_chk
bind ioc_top ioc_chk u_chk (.mclk(mclk), .rst_n(rst_n), .chan_rw_active(chan_rw_active),
    .ext_irq_in(ext_irq_in), .reply_in(reply_in), .reject_in(reject_in),
    .ext_irq_out(ext_irq_out), .chan_code_q(chan_code_q), .connect_en_q(connect_en_q),
    .func_en_q(func_en_q), .chan_clear_q(chan_clear_q), .equip_clear_q(equip_clear_q),
    .start_io_q(start_io_q));

/* ioc_peer.sv */
// external controller model answering connect and function enables
`timescale 1ns/1ps
module ioc_peer (
    input wire mclk,
    input wire [7:0] en,
    input wire [1:0] mode,
    input wire [15:0] dly,
    output reg [7:0] reply_in,
    output reg [7:0] reject_in
);
    reg [15:0] n_q;
    initial begin
        reply_in = 8'h00;
        reject_in = 8'h00;
        n_q = 16'h0000;
    end
    // mode 0 silent, 1 reply, 2 reject; answer after dly cycles
    always @(posedge mclk) begin
        if (en == 8'h00) begin
            n_q <= 16'h0000;
            reply_in <= 8'h00;
            reject_in <= 8'h00;
        end else begin
            n_q <= n_q + 16'h0001;
            if (n_q == dly && mode == 2'h1) reply_in <= en;
            if (n_q == dly && mode == 2'h2) reject_in <= en;
        end
    end
endmodule // ioc_peer

/* ioc_top_tb.sv */
// self-checking bench for the i/o channel control block
`timescale 1ns/1ps
`include "ioc_map.vh"
module ioc_top_tb;
    reg mclk, rst_n, aw_v, w_v, b_r, ar_v, r_r, mon_clr;
    reg [7:0] awaddr, araddr, rw, term, neg, irq;
    reg [31:0] wdata;
    reg [1:0] pmode;
    reg [15:0] pdly;
    reg [7:0] clr_s, eq_s, st_s, en_s;
    reg [1:0] ts_s;
    reg [11:0] code_s;
    integer bad_count, num_checks, cyc;
    wire awready, wready, bvalid, arready, rvalid, type_clear_q, search_move_clear_q;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [7:0] reply_in, reject_in, irq_out, connect_en_q, func_en_q;
    wire [7:0] chan_clear_q, equip_clear_q, start_io_q;
    wire [11:0] chan_code_q;
    ioc_top dut (.mclk(mclk), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(aw_v),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(w_v),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(b_r),
        .s_axi_araddr(araddr), .s_axi_arvalid(ar_v), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(r_r),
        .chan_rw_active(rw), .chan_terminate(term), .negate_lockout(neg), .ext_irq_in(irq),
        .reply_in(reply_in), .reject_in(reject_in), .ext_irq_out(irq_out),
        .chan_code_q(chan_code_q), .connect_en_q(connect_en_q), .func_en_q(func_en_q),
        .chan_clear_q(chan_clear_q), .equip_clear_q(equip_clear_q), .start_io_q(start_io_q),
        .type_clear_q(type_clear_q), .search_move_clear_q(search_move_clear_q));
    ioc_peer u_peer (.mclk(mclk), .en(connect_en_q | func_en_q), .mode(pmode), .dly(pdly),
        .reply_in(reply_in), .reject_in(reject_in));
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    // sticky capture of clear, start, unit-clear and enable outputs, plus the code seen while an enable is high
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 70000) begin
            bad_count = bad_count + 1;
            summarize;
        end
        if (mon_clr) begin
            {clr_s, eq_s, st_s, en_s, ts_s} <= 34'h0;
        end else begin
            clr_s <= clr_s | chan_clear_q;
            eq_s <= eq_s | equip_clear_q;
            st_s <= st_s | start_io_q;
            en_s <= en_s | connect_en_q | func_en_q;
            ts_s <= ts_s | {search_move_clear_q, type_clear_q};
            if (|(connect_en_q | func_en_q)) code_s <= chan_code_q;
        end
    end
    task summarize;
        begin
            $display("checks %0d mismatches %0d", num_checks, bad_count);
            if (bad_count == 0 && num_checks > 0)
                $display("bench passed");
            else
                $display("bench failed");
            $finish;
        end
    endtask
    task chk(input [8*10:1] nm, input [31:0] e, input [31:0] g);
        begin
            num_checks = num_checks + 1;
            if (g !== e) begin
                bad_count = bad_count + 1;
                $display("MISMATCH %0s expected %h seen %h", nm, e, g);
            end
        end
    endtask
    task axw(input [7:0] a, input [31:0] d, output [1:0] r);
        reg done;
        begin
            awaddr <= a;
            wdata <= d;
            {aw_v, w_v, b_r} <= 3'h7;
            done = 1'b0;
            while (!done) begin
                @(posedge mclk);
                if (awready) aw_v <= 1'b0;
                if (wready) w_v <= 1'b0;
                if (bvalid) {done, r} = {1'b1, bresp};
            end
            b_r <= 1'b0;
            @(posedge mclk);
        end
    endtask
    task rd(input [7:0] a, output [31:0] d, output [1:0] r);
        reg done;
        begin
            araddr <= a;
            {ar_v, r_r} <= 2'h3;
            done = 1'b0;
            while (!done) begin
                @(posedge mclk);
                if (arready) ar_v <= 1'b0;
                if (rvalid) {done, d, r} = {1'b1, rdata, rresp};
            end
            r_r <= 1'b0;
            @(posedge mclk);
        end
    endtask
    task wr(input [7:0] a, input [31:0] d);
        reg [1:0] r;
        begin
            axw(a, d, r);
            chk("bresp", 32'h0, 32'(r));
        end
    endtask
    task cmd(input [3:0] op, input [31:0] d);
        begin
            mon_clr <= 1'b1;
            @(posedge mclk);
            mon_clr <= 1'b0;
            wr(`IOC_A_CMD, {4'h0, op, 24'h0} | d);
        end
    endtask
    task t_regs;
        reg [31:0] d;
        reg [1:0] r;
        begin
            rd(`IOC_A_LOCK, d, r);
            chk("lock rst", 32'h0, d);
            rd(8'h40, d, r);
            chk("rd unmap", 32'h2, {d[29:0], r});
            axw(8'h44, 32'h1, r);
            chk("wr unmap", 32'h2, 32'(r));
        end
    endtask
    task t_faults;
        reg [31:0] d;
        reg [1:0] r;
        begin
            cmd(`IOC_OP_SET_FLOAT_FAULT_OP, 32'h0);
            rd(`IOC_A_STAT, d, r);
            chk("float", 32'h1, 32'(d[1:0]));
            cmd(`IOC_OP_SET_DECIMAL_FAULT_OP, 32'h0);
            rd(`IOC_A_STAT, d, r);
            chk("bcd", 32'h3, 32'(d[1:0]));
            cmd(`IOC_OP_CLRFLT, 32'h3);
        end
    endtask
    task t_lock;
        reg [31:0] d;
        reg [1:0] r;
        begin
            cmd(`IOC_OP_LOCKOUT, 32'h005);
            rd(`IOC_A_LOCK, d, r);
            chk("lock", 32'h5, d);
            rw <= 8'h01;
            irq <= 8'h05;
            repeat (4) @(posedge mclk);
            chk("irq out", 32'h4, 32'(irq_out));
            {rw, term} <= 16'h0001;
            @(posedge mclk);
            term <= 8'h00;
            rd(`IOC_A_LOCK, d, r);
            chk("lock term", 32'h4, d);
            neg <= 8'h04;
            @(posedge mclk);
            {neg, irq} <= 16'h0;
            rd(`IOC_A_LOCK, d, r);
            chk("lock neg", 32'h0, d);
            cmd(`IOC_OP_LOCKOUT, 32'h003);
            cmd(`IOC_OP_CLEAR_CHANNELS_OP, 32'h001);
            rd(`IOC_A_LOCK, d, r);
            chk("lock clr", 32'h2, d);
            chk("clr sel", 32'h1, 32'(clr_s));
            chk("no equip", 32'h0, 32'(eq_s));
        end
    endtask
    task t_blk;
        reg [11:0] m;
        integer i;
        begin
            for (i = 0; i < 3; i = i + 1) begin
                m = (i == 0) ? 12'h103 : (i == 1) ? 12'he0c : 12'h430;
                cmd(`IOC_OP_BCCLR, 32'(m));
                repeat (1200) @(posedge mclk);
                chk("blk chan", 32'(m[7:0]), 32'(clr_s));
                chk("blk equip", (m[9] == m[10]) ? 32'(m[7:0]) : 32'h0, 32'(eq_s));
                chk("blk units", 32'({m[11], m[8]}), 32'(ts_s));
            end
        end
    endtask
    task t_conn;
        reg [31:0] d;
        reg [1:0] r;
        reg [2:0] ex;
        integer i;
        begin
            for (i = 0; i < 5; i = i + 1) begin
                pmode <= (i < 2) ? 2'h1 : (i == 2) ? 2'h2 : 2'h0;
                pdly <= (i == 1) ? 16'd15000 : 16'd3;
                rw <= (i == 4) ? 8'h10 : 8'h00;
                ex = (i < 2) ? 3'h1 : (i == 3) ? 3'h2 : (i == 4) ? 3'h4 : 3'h0;
                cmd(i[0] ? `IOC_OP_FSEL : `IOC_OP_CONN, {17'h0, i[2:0], 12'h5a0} | i);
                d = 32'h0;
                while (d[7:6] != 2'h2) rd(`IOC_A_STAT, d, r);
                chk("hs result", 32'(ex), 32'(d[5:3]));
                chk("enable", (i == 4) ? 32'h0 : 32'h1 << i, 32'(en_s));
                if (i != 4) chk("code", 32'h5a0 | i, 32'(code_s));
                rw <= 8'h00;
                repeat (4) @(posedge mclk);
            end
        end
    endtask
    task t_stio;
        reg [31:0] d, f, l;
        reg [1:0] r;
        reg [2:0] c, dg;
        integer i, sh;
        begin
            for (i = 0; i < 9; i = i + 1) begin
                c = i[2:0];
                sh = (c == 3'h0 || c == 3'h2) ? 2 : 0;
                dg = (i == 8) ? 3'h5 : c;
                wr(`IOC_A_ADDR, 32'h40 + i);
                wr(`IOC_A_LAST, 32'h80 + i);
                cmd(`IOC_OP_STIO, {9'h0, 3'h5, i == 8, c, 1'b0, c, 12'h0});
                chk("start", 32'h1 << c, 32'(st_s));
                f = (32'h40 + i) << sh;
                l = (32'h80 + i) << sh;
                wr(`IOC_A_RFADR, 32'(c));
                rd(`IOC_A_RFDAT, d, r);
                chk("cur word", {8'h0, dg, f[20:0]}, d);
                wr(`IOC_A_RFADR, 32'h8 | c);
                rd(`IOC_A_RFDAT, d, r);
                chk("last word", l, d);
            end
        end
    endtask
    initial begin
        {rst_n, aw_v, w_v, b_r, ar_v, r_r, mon_clr} = 7'h01;
        {awaddr, araddr, rw, term, neg, irq, wdata} = 80'h0;
        {pmode, pdly, bad_count, num_checks, cyc} = 0;
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (4) @(posedge mclk);
        t_regs;
        t_faults;
        t_lock;
        t_blk;
        t_conn;
        t_stio;
        summarize;
    end
endmodule // ioc_top_tb
